/* core/acp_pkg.sv */
/*
 * Shared constants and types for the average-current pulse monitor.
 * Assumes a 125 MHz pclk, APB register access and a 0.1 s timebase.
 */
// How it works
// - Repeat 20 s cycles during constant speed.
// - One second high start bit; average current.
// - Averaging window 0.1 to 1 s, default 1 s.
// - Settle mask 0 to 20 s, default zero.
// - Reference current 0 to 500 A sets 100 percent.
// - Low pulse equals average over reference times 5 s.
// - Low pulse clamped 0.5 s to 9 s.
// - High pulse encodes hours counter, 40000 h per 5 s.
// - High pulse clamped 2 s to 9 s.
// - No masking or sampling while accelerating/decelerating.
// - Ramp during start bit: 3.5 s high, 16.5 s low.
// - Completed start bit always finishes its cycle.
// - Zero current at cycle end halts until next constant speed.
// - Data-free 20 s low cycle on ramp or restart.
// - Output via selector A or B, code 93 or 193.
// - Monitor settings writable at any time.
// - Hours counter in 100 h units, saturating at 9998.

package acp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timebase.
    localparam int CLK_FREQ_KHZ = 125000;
    localparam int TICK_TIME_MS = 100;
    localparam int TICK_CYCLES = TICK_TIME_MS * CLK_FREQ_KHZ;

    // Durations in milliseconds and the matching tick counts.
    localparam int CYCLE_TIME_MS = 20000;
    localparam int START_TIME_MS = 1000;
    localparam int INVALID_HIGH_MS = 3500;
    localparam int LOW_MIN_MS = 500;
    localparam int LOW_MAX_MS = 9000;
    localparam int HIGH_MIN_MS = 2000;
    localparam int HIGH_MAX_MS = 9000;
    localparam int FULL_SCALE_MS = 5000;
    localparam logic [7:0] CYCLE_TICKS = 8'(CYCLE_TIME_MS / TICK_TIME_MS);
    localparam logic [7:0] START_TICKS = 8'(START_TIME_MS / TICK_TIME_MS);
    localparam logic [7:0] INVALID_HIGH_TICKS = 8'(INVALID_HIGH_MS / TICK_TIME_MS);
    localparam logic [7:0] LOW_MIN_TICKS = 8'(LOW_MIN_MS / TICK_TIME_MS);
    localparam logic [7:0] LOW_MAX_TICKS = 8'(LOW_MAX_MS / TICK_TIME_MS);
    localparam logic [7:0] HIGH_MIN_TICKS = 8'(HIGH_MIN_MS / TICK_TIME_MS);
    localparam logic [7:0] HIGH_MAX_TICKS = 8'(HIGH_MAX_MS / TICK_TIME_MS);
    localparam logic [5:0] FULL_SCALE_TICKS = 6'(FULL_SCALE_MS / TICK_TIME_MS);

    // Hours counter: 100 h units, 40000 h is full scale, so ticks = count / 8.
    localparam logic [13:0] HOURS_SAT = 14'd9998;
    localparam int HOURS_SHIFT = 3;

    // Settings: window and mask in 0.1 s ticks, current in 0.1 A.
    localparam logic [15:0] AVG_WIN_MIN = 16'h0001;
    localparam logic [15:0] AVG_WIN_MAX = 16'h000a;
    localparam logic [15:0] AVG_WIN_RESET = 16'h000a;
    localparam logic [15:0] MASK_MAX = 16'h00c8;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [15:0] REF_MAX = 16'h1388;
    localparam logic [15:0] RATED_CURRENT_RESET = 16'h0032;
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [7:0] SEL_POSITIVE = 8'h5d;
    localparam logic [7:0] SEL_NEGATIVE = 8'hc1;
    localparam logic [15:0] RESTART_OFF = 16'h270f;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [7:0] OFF_AVG_WIN = 8'h00;
    localparam logic [7:0] OFF_MASK = 8'h04;
    localparam logic [7:0] OFF_REF = 8'h08;
    localparam logic [7:0] OFF_SEL_A = 8'h0c;
    localparam logic [7:0] OFF_SEL_B = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;

    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [3:0] {
        ACP_IDLE, ACP_MASK, ACP_START, ACP_LOWP, ACP_HIGHP, ACP_TAIL,
        ACP_INVH, ACP_INVL, ACP_EMPTY
    } acp_state_e;

    // Drive status from the motor control logic, same clock.
    typedef struct packed {
        logic const_speed;
        logic accel_decel;
        logic restart_active;
    } acp_drive_s;

endpackage

/* core/acp_tick.sv */
/*
 * Timebase divider: one-cycle enable pulse every TICK_CYCLES clocks.
 * Assumes a free-running pclk.
 */
`timescale 1ns/1ps
`default_nettype none

module acp_tick #(
    parameter int TICK_CYCLES = 12500000
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Tick
    output logic tick
);

    logic [31:0] count_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= 32'h0000_0000;
            tick <= 1'b0;
        end else if (count_r >= 32'(TICK_CYCLES - 1)) begin
            count_r <= 32'h0000_0000;
            tick <= 1'b1;
        end else begin
            count_r <= count_r + 32'h0000_0001;
            tick <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* core/acp_monitor.sv */
/*
 * Average-current pulse monitor: a 20 s pulse-coded frame with a start
 * bit, a current-coded low pulse and an hours-coded high pulse.
 * Assumes drive status, current and hours come from same-clock logic.
 */
`timescale 1ns/1ps
`default_nettype none

module acp_monitor
    import acp_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Drive inputs
    input wire acp_drive_s drive,
    input wire logic [15:0] output_current,
    input wire logic [13:0] energized_hours_counter,
    input wire logic [15:0] restart_coast_time_setting,
    // Monitor outputs
    output logic avg_current_pulse_out,
    output logic term_a,
    output logic term_b
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and internal state.
    logic tick;
    logic [15:0] averaging_window_setting_r;
    logic [15:0] settle_mask_setting_r;
    logic [15:0] reference_current_setting_r;
    logic [7:0] output_selector_a_r;
    logic [7:0] output_selector_b_r;
    acp_state_e state_r, state_nxt;
    logic [7:0] cyc_r, cyc_nxt;
    logic [15:0] mask_cnt_r;
    logic halted_r;
    logic const_prev_r;
    logic [19:0] sum_r;
    logic [3:0] nsamp_r;
    logic [25:0] div_num_r;
    logic [20:0] div_rem_r;
    logic [19:0] div_den_r;
    logic [4:0] div_cnt_r;
    logic div_busy_r;
    logic [7:0] low_ticks_r;
    logic [7:0] high_ticks_r;
    logic start_enter;
    logic start_done;
    logic restart_on;
    logic pulse_level;
    logic [13:0] hours_sat;
    logic [10:0] hours_ticks;
    logic [20:0] rem_shift;

    acp_tick #(
        .TICK_CYCLES(TICK_LEN)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    assign restart_on = drive.restart_active && (restart_coast_time_setting != RESTART_OFF);

    ////////////////////////////////////////////////////////////////////////////
    // Register writes take effect in the access phase; no write lock exists.
    logic wr_en;
    assign wr_en = psel && penable && pready && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            averaging_window_setting_r <= AVG_WIN_RESET;
            settle_mask_setting_r <= MASK_RESET;
            reference_current_setting_r <= RATED_CURRENT_RESET;
            output_selector_a_r <= SEL_RESET;
            output_selector_b_r <= SEL_RESET;
        end else if (wr_en) begin
            unique case (paddr)
                OFF_AVG_WIN: begin
                    if (pwdata[15:0] < AVG_WIN_MIN) begin
                        averaging_window_setting_r <= AVG_WIN_MIN;
                    end else if (pwdata[15:0] > AVG_WIN_MAX) begin
                        averaging_window_setting_r <= AVG_WIN_MAX;
                    end else begin
                        averaging_window_setting_r <= pwdata[15:0];
                    end
                end
                OFF_MASK: begin
                    settle_mask_setting_r <= (pwdata[15:0] > MASK_MAX) ? MASK_MAX : pwdata[15:0];
                end
                OFF_REF: begin
                    reference_current_setting_r <= (pwdata[15:0] > REF_MAX) ? REF_MAX
                        : pwdata[15:0];
                end
                OFF_SEL_A: output_selector_a_r <= pwdata[7:0];
                OFF_SEL_B: output_selector_b_r <= pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // Read data is captured in the setup phase so the access phase can answer at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                unique case (paddr)
                    OFF_AVG_WIN: prdata <= {16'h0000, averaging_window_setting_r};
                    OFF_MASK: prdata <= {16'h0000, settle_mask_setting_r};
                    OFF_REF: prdata <= {16'h0000, reference_current_setting_r};
                    OFF_SEL_A: prdata <= {24'h00_0000, output_selector_a_r};
                    OFF_SEL_B: prdata <= {24'h00_0000, output_selector_b_r};
                    OFF_STATUS: prdata <= {3'b000, halted_r, state_r, high_ticks_r, low_ticks_r, cyc_r};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame sequencer. Phase boundaries are counted in 0.1 s ticks from cycle start.
    assign start_done = (state_r == ACP_START) && tick && (cyc_r + 8'h01 >= START_TICKS);

    always_comb begin
        state_nxt = state_r;
        cyc_nxt = cyc_r;
        start_enter = 1'b0;
        unique case (state_r)
            ACP_IDLE: begin
                if (drive.const_speed && !drive.accel_decel && !halted_r) begin
                    state_nxt = ACP_MASK;
                end
            end
            ACP_MASK: begin
                if (!drive.const_speed || drive.accel_decel) begin
                    state_nxt = ACP_IDLE;
                end else if (mask_cnt_r >= settle_mask_setting_r) begin
                    cyc_nxt = 8'h00;
                    if (restart_on) begin
                        state_nxt = ACP_EMPTY;
                    end else begin
                        state_nxt = ACP_START;
                        start_enter = 1'b1;
                    end
                end
            end
            ACP_START: begin
                if (drive.accel_decel) begin
                    state_nxt = ACP_INVH;
                end else if (tick) begin
                    cyc_nxt = cyc_r + 8'h01;
                    if (start_done) begin
                        state_nxt = ACP_LOWP;
                    end
                end
            end
            default: begin
                if (tick) begin
                    cyc_nxt = cyc_r + 8'h01;
                    if (state_r == ACP_LOWP && cyc_nxt >= START_TICKS + low_ticks_r) begin
                        state_nxt = ACP_HIGHP;
                    end else if (state_r == ACP_HIGHP
                            && cyc_nxt >= START_TICKS + low_ticks_r + high_ticks_r) begin
                        state_nxt = ACP_TAIL;
                    end else if (state_r == ACP_INVH && cyc_nxt >= INVALID_HIGH_TICKS) begin
                        state_nxt = ACP_INVL;
                    end else if (cyc_nxt >= CYCLE_TICKS) begin
                        cyc_nxt = 8'h00;
                        if (output_current == 16'h0000) begin
                            state_nxt = ACP_IDLE;
                        end else if (drive.accel_decel || restart_on) begin
                            state_nxt = ACP_EMPTY;
                        end else if (drive.const_speed) begin
                            state_nxt = ACP_START;
                            start_enter = 1'b1;
                        end else begin
                            state_nxt = ACP_IDLE;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ACP_IDLE;
            cyc_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            cyc_r <= cyc_nxt;
        end
    end

    // Settling mask counts only at steady constant speed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_cnt_r <= 16'h0000;
        end else if (state_r != ACP_MASK || drive.accel_decel) begin
            mask_cnt_r <= 16'h0000;
        end else if (tick) begin
            mask_cnt_r <= mask_cnt_r + 16'h0001;
        end
    end

    // Halt after a zero-current cycle end, released on the next entry to constant speed.
    // A halt and a release in the same cycle leave the block halted.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halted_r <= 1'b0;
            const_prev_r <= 1'b0;
        end else begin
            const_prev_r <= drive.const_speed;
            if (state_r != ACP_IDLE && state_r != ACP_MASK && state_nxt == ACP_IDLE
                    && cyc_nxt == 8'h00 && output_current == 16'h0000) begin
                halted_r <= 1'b1;
            end else if (drive.const_speed && !const_prev_r) begin
                halted_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Current samples, one per tick over the first window ticks of the start bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sum_r <= 20'h0_0000;
            nsamp_r <= 4'h0;
        end else if (start_enter) begin
            sum_r <= 20'h0_0000;
            nsamp_r <= 4'h0;
        end else if (state_r == ACP_START && tick && !drive.accel_decel
                && {8'h00, cyc_r} < averaging_window_setting_r) begin
            sum_r <= sum_r + {4'h0, output_current};
            nsamp_r <= nsamp_r + 4'h1;
        end
    end

    // Restoring divider: (sum * 50) / (samples * reference). A zero divisor saturates.
    assign rem_shift = {div_rem_r[19:0], div_num_r[25]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_num_r <= 26'h000_0000;
            div_rem_r <= 21'h00_0000;
            div_den_r <= 20'h0_0000;
            div_cnt_r <= 5'h00;
            div_busy_r <= 1'b0;
        end else if (start_done && !drive.accel_decel) begin
            div_num_r <= 26'(sum_r * FULL_SCALE_TICKS);
            div_den_r <= 20'(nsamp_r * reference_current_setting_r);
            div_rem_r <= 21'h00_0000;
            div_cnt_r <= 5'd26;
            div_busy_r <= 1'b1;
        end else if (div_busy_r) begin
            if (rem_shift >= {1'b0, div_den_r}) begin
                div_rem_r <= rem_shift - {1'b0, div_den_r};
                div_num_r <= {div_num_r[24:0], 1'b1};
            end else begin
                div_rem_r <= rem_shift;
                div_num_r <= {div_num_r[24:0], 1'b0};
            end
            div_cnt_r <= div_cnt_r - 5'h01;
            div_busy_r <= (div_cnt_r != 5'h01);
        end
    end

    // Pulse widths; the divider settles in 27 clocks, inside the shortest low pulse
    // only when a tick lasts 6 clocks or more.
    assign hours_sat = (energized_hours_counter > HOURS_SAT) ? HOURS_SAT
        : energized_hours_counter;
    assign hours_ticks = 11'(hours_sat >> HOURS_SHIFT);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_ticks_r <= LOW_MIN_TICKS;
            high_ticks_r <= HIGH_MIN_TICKS;
        end else begin
            if (state_r == ACP_LOWP && !div_busy_r) begin
                if (div_num_r < {18'h0_0000, LOW_MIN_TICKS}) begin
                    low_ticks_r <= LOW_MIN_TICKS;
                end else if (div_num_r > {18'h0_0000, LOW_MAX_TICKS}) begin
                    low_ticks_r <= LOW_MAX_TICKS;
                end else begin
                    low_ticks_r <= div_num_r[7:0];
                end
            end
            if (start_done) begin
                if (hours_ticks < {3'b000, HIGH_MIN_TICKS}) begin
                    high_ticks_r <= HIGH_MIN_TICKS;
                end else if (hours_ticks > {3'b000, HIGH_MAX_TICKS}) begin
                    high_ticks_r <= HIGH_MAX_TICKS;
                end else begin
                    high_ticks_r <= hours_ticks[7:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output stage. Terminals follow the selector code and its polarity.
    assign pulse_level = (state_nxt == ACP_START) || (state_nxt == ACP_HIGHP)
        || (state_nxt == ACP_INVH);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            avg_current_pulse_out <= 1'b0;
            term_a <= 1'b0;
            term_b <= 1'b0;
        end else begin
            avg_current_pulse_out <= pulse_level;
            term_a <= (output_selector_a_r == SEL_POSITIVE) ? pulse_level
                : (output_selector_a_r == SEL_NEGATIVE) ? !pulse_level : 1'b0;
            term_b <= (output_selector_b_r == SEL_POSITIVE) ? pulse_level
                : (output_selector_b_r == SEL_NEGATIVE) ? !pulse_level : 1'b0;
        end
    end

endmodule

`default_nettype wire

/* bench/acp_monitor_checker.sv */
/*
 * Port-level checker for the average-current pulse monitor.
 * Assumes it is bound into acp_monitor and shares its TICK_LEN.
 */
`timescale 1ns/1ps
`default_nettype none

module acp_monitor_checker #(
    parameter int TICK_LEN = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Monitor
    input wire logic avg_current_pulse_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////////
    // Run lengths of the pulse line, in clocks.
    int hi_cnt_r;
    int lo_cnt_r;
    logic seen_hi_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hi_cnt_r <= 0;
        else if (avg_current_pulse_out) hi_cnt_r <= hi_cnt_r + 1;
        else hi_cnt_r <= 0;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) lo_cnt_r <= 0;
        else if (!avg_current_pulse_out) lo_cnt_r <= lo_cnt_r + 1;
        else lo_cnt_r <= 0;
    end
    // The idle low before the first frame has no lower bound.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) seen_hi_r <= 1'b0;
        else if (avg_current_pulse_out) seen_hi_r <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_PREADY_FIRST: assert property (psel && !penable |=> pready)
        else $error("pready missing in first access cycle");
    AST_PREADY_ONE: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_UNMAPPED: assert property (psel && !penable && paddr >= 8'h18 |=> pslverr)
        else $error("unmapped address not refused");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data not zero outside access");
    AST_HIGH_MIN: assert property ($fell(avg_current_pulse_out) |-> hi_cnt_r >= 9 * TICK_LEN)
        else $error("high pulse too short");
    AST_HIGH_MAX: assert property (hi_cnt_r <= 90 * TICK_LEN)
        else $error("high pulse too long");
    AST_LOW_MIN: assert property ($rose(avg_current_pulse_out) && seen_hi_r
        |-> lo_cnt_r >= 5 * TICK_LEN)
        else $error("low pulse too short");

    C_FRAME: cover property ($fell(avg_current_pulse_out));
    C_INVALID: cover property ($fell(avg_current_pulse_out) && hi_cnt_r == 35 * TICK_LEN);
    C_REFUSED: cover property (pslverr);
endmodule

bind acp_monitor acp_monitor_checker #(.TICK_LEN(TICK_LEN)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .avg_current_pulse_out(avg_current_pulse_out));

`default_nettype wire

/* bench/acp_plc_model.sv */
/*
 * PLC input module model: measures each level run of the pulse line
 * and queues its width in ticks, rounded up.
 * Assumes the line is a registered level on pclk.
 */
`timescale 1ns/1ps
`default_nettype none

module acp_plc_model #(
    parameter int TICK_LEN = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Measured line
    input wire logic pulse_in
);
    int widths[$];
    int run_len;
    logic last_lvl;

    // Rounding up absorbs the start bit, which may begin between ticks.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_len = 0;
            last_lvl = 1'b0;
            widths.delete();
        end else if (pulse_in !== last_lvl) begin
            widths.push_back((run_len + TICK_LEN - 1) / TICK_LEN);
            run_len = 1;
            last_lvl = pulse_in;
        end else begin
            run_len++;
        end
    end
endmodule

`default_nettype wire

/* bench/tb_acp_monitor.sv */
/*
 * Self-checking bench for acp_monitor: APB register checks and
 * measured pulse frames. Assumes a short TICK_LEN for run time.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_acp_monitor;
    import acp_pkg::*;
    localparam int TL = 8;
    localparam int LIMIT = 20000;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic err, avg_current_pulse_out, term_a, term_b;
    acp_drive_s drive;
    logic [15:0] output_current, restart_coast_time_setting;
    logic [13:0] energized_hours_counter;
    int n_fail = 0;
    int tests_run = 0;
    logic [7:0] rst_addr [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    logic [31:0] rst_val [5] = '{32'h0a, 32'h00, 32'h32, 32'h00, 32'h00};
    logic [31:0] clp_wr [3] = '{32'h0, 32'h12c, 32'h1770};
    logic [31:0] clp_exp [3] = '{32'h1, 32'hc8, 32'h1388};

    acp_monitor #(.TICK_LEN(TL)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .drive(drive),
        .output_current(output_current), .energized_hours_counter(energized_hours_counter),
        .restart_coast_time_setting(restart_coast_time_setting),
        .avg_current_pulse_out(avg_current_pulse_out), .term_a(term_a), .term_b(term_b));
    acp_plc_model #(.TICK_LEN(TL)) plc (.pclk(pclk), .presetn(presetn), .pulse_in(term_a));

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("counts: %0d compared, %0d mismatched", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_int(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            n_fail++;
            $display("mismatch at %0t: width %0d expected %0d", $time, got, exp);
        end
    endtask
    // Holds the request until pready is seen high at a rising edge, giving up after 20 more cycles.
    task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        cmp_word({31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic check_next(input int exp);
        int n;
        n = 0;
        while (plc.widths.size() == 0 && n < 400 * TL) begin
            @(posedge pclk);
            n++;
        end
        if (plc.widths.size() == 0) cmp_int(-1, exp);
        else cmp_int(plc.widths.pop_front(), exp);
    endtask
    task automatic wait_high();
        int n;
        n = 0;
        while (term_a !== 1'b1 && n < 400 * TL) begin
            @(posedge pclk);
            n++;
        end
        cmp_word({31'h0, term_a}, 32'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        int cyc;
        cyc = 0;
        forever begin
            @(posedge pclk);
            cyc++;
            if (cyc == LIMIT) begin
                n_fail++;
                $display("mismatch at %0t: run did not finish", $time);
                tally_and_finish();
            end
        end
    end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; drive = '0; output_current = 16'h0;
        energized_hours_counter = 14'h0; restart_coast_time_setting = RESTART_OFF;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb_xfer(1'b0, rst_addr[i], 32'h0);
            cmp_word(rd, rst_val[i]);
        end
        for (int i = 0; i < 3; i++) begin
            apb_xfer(1'b1, rst_addr[i], clp_wr[i]);
            apb_xfer(1'b0, rst_addr[i], 32'h0);
            cmp_word(rd, clp_exp[i]);
        end
        apb_xfer(1'b0, 8'h18, 32'h0);
        cmp_word({31'h0, err}, 32'h1);
        cmp_word(rd, 32'h0);
        $display("test registers done");
        apb_xfer(1'b1, OFF_AVG_WIN, 32'h0a);
        apb_xfer(1'b1, OFF_MASK, 32'h0);
        apb_xfer(1'b1, OFF_REF, 32'h64);
        apb_xfer(1'b1, OFF_SEL_A, 32'd93);
        apb_xfer(1'b1, OFF_SEL_B, 32'd193);
        @(posedge pclk);
        output_current <= 16'd150;
        energized_hours_counter <= 14'd400;
        drive.const_speed <= 1'b1;
        wait_high();
        @(posedge pclk);
        plc.widths.delete();
        check_next(10);
        check_next(150 * 50 / 100);
        check_next(400 / 8);
        output_current <= 16'd5;
        energized_hours_counter <= 14'd9999;
        check_next(200 - 10 - 75 - 50);
        $display("test nominal frame done");
        check_next(10);
        check_next(5);
        check_next(90);
        restart_coast_time_setting <= 16'h0001;
        drive.restart_active <= 1'b1;
        repeat (150 * TL) @(posedge pclk);
        restart_coast_time_setting <= RESTART_OFF;
        drive.restart_active <= 1'b0;
        check_next(200 - 10 - 5 - 90 + 200);
        $display("test clamp and empty frame done");
        @(posedge pclk);
        drive.accel_decel <= 1'b1;
        repeat (2) @(posedge pclk);
        drive.accel_decel <= 1'b0;
        check_next(35);
        output_current <= 16'd0;
        repeat (200 * TL) @(posedge pclk);
        cmp_int(plc.widths.size(), 0);
        cmp_word({31'h0, term_a}, 32'h0);
        apb_xfer(1'b0, OFF_STATUS, 32'h0);
        cmp_word({31'h0, rd[28]}, 32'h1);
        $display("test invalid and halt done");
        drive.const_speed <= 1'b0;
        output_current <= 16'd150;
        @(posedge pclk);
        drive.const_speed <= 1'b1;
        wait_high();
        cmp_word({31'h0, term_b}, 32'h0);
        cmp_word({31'h0, avg_current_pulse_out}, 32'h1);
        $display("test resume done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
